// [design/hbc_bridge_ctrl.sv]
// module: brushed dc h-bridge control with ahb-lite register slave
// ==================================================
// Functional notes
// - enable low, non-brake inputs: all off
// - enable high: forward or reverse by inputs
// - device inserts its own break-before-make
// - both low: low brake; all high: high brake
// - input a picks half-bridge a switch
// - input b picks half-bridge b switch
// - enable pwm gates the output drive
// - supply falling with enable high: fault
// - low-side chopping limits sense current
// - detector trip: fault low, all off
// - output short after 16us of enable high latches outputs off
// - only power-on reset clears fault
// - overcurrent comparator trip shuts output off
module hbc_bridge_ctrl
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              ce,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire hbc_pkg::hbc_pins_t pins,
	output hbc_pkg::hbc_gate_t     gates,
	output logic                   fault_n,
	output logic                   irq
);
	// ==================================================
	// functions
	function automatic hbc_pkg::hbc_gate_t decode_drive
	(
		input logic a,
		input logic b,
		input logic en
	);
		hbc_pkg::hbc_gate_t g;
		g = '0;
		if (!a && !b)
		begin
			g.low_switch_a = 1'b1;
			g.low_switch_b = 1'b1;
		end
		else if (en && a && b)
		begin
			g.high_switch_a = 1'b1;
			g.high_switch_b = 1'b1;
		end
		else if (en)
		begin
			g.high_switch_a = ~a;
			g.low_switch_a  = a;
			g.high_switch_b = ~b;
			g.low_switch_b  = b;
		end
		return g;
	endfunction

	function automatic logic [31:0] read_sel
	(
		input logic [hbc_pkg::ADDR_W-1:0] a,
		input logic [31:0]                ctrl,
		input logic [31:0]                stat,
		input logic [31:0]                ists,
		input logic [31:0]                ien
	);
		logic [31:0] d;
		d = '0;
		if (a == hbc_pkg::ADDR_CTRL)
			d = ctrl;
		else if (a == hbc_pkg::ADDR_STATUS)
			d = stat;
		else if (a == hbc_pkg::ADDR_IRQ_STAT)
			d = ists;
		else if (a == hbc_pkg::ADDR_IRQ_EN)
			d = ien;
		return d;
	endfunction

	// ==================================================
	// declarations
	hbc_pkg::hbc_pins_t          meta_ff;
	hbc_pkg::hbc_pins_t          sync_ff;
	hbc_pkg::hbc_state_t         state_ff;
	hbc_pkg::hbc_state_t         nxt_state;
	hbc_pkg::hbc_gate_t          gate_ff;
	hbc_pkg::hbc_gate_t          nxt_gate;
	hbc_pkg::hbc_gate_t          tgt;
	hbc_pkg::hbc_status_t        status;
	logic [hbc_pkg::DEAD_W-1:0]  dead_cnt_ff;
	logic [hbc_pkg::DEAD_W-1:0]  nxt_dead_cnt;
	logic [hbc_pkg::QUAL_W-1:0]  qual_cnt_ff;
	logic [hbc_pkg::QUAL_W-1:0]  nxt_qual_cnt;
	logic [hbc_pkg::CHOP_W-1:0]  chop_cnt_ff;
	logic [hbc_pkg::CHOP_W-1:0]  nxt_chop_cnt;
	logic                        chop_ff;
	logic                        nxt_chop;
	logic                        fault_ff;
	logic                        nxt_fault;
	logic                        fault_n_ff;
	logic                        irq_ff;
	logic [31:0]                 ctrl_ff;
	logic [31:0]                 nxt_ctrl;
	logic [hbc_pkg::IRQ_W-1:0]   ists_ff;
	logic [hbc_pkg::IRQ_W-1:0]   nxt_ists;
	logic [hbc_pkg::IRQ_W-1:0]   ien_ff;
	logic [hbc_pkg::IRQ_W-1:0]   nxt_ien;
	logic [hbc_pkg::IRQ_W-1:0]   irq_ev;
	logic [hbc_pkg::IRQ_W-1:0]   irq_clr;
	logic                        wr_pend_ff;
	logic [hbc_pkg::ADDR_W-1:0]  wr_addr_ff;
	logic [31:0]                 hrdata_ff;
	logic                        hreadyout_ff;
	logic                        hresp_ff;
	wire                         chop_tick;
	wire                         trip;
	wire                         short_trip;
	wire                         hazard;
	wire                         addr_ok;
	wire                         rd_go;
	wire                         wr_go;
	wire  [31:0]                 rd_data;
	wire                         wr_ctrl;
	wire                         wr_clr;
	wire                         wr_ien;

	// ==================================================
	// pin synchronisers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else if (ce)
		begin
			meta_ff <= pins;
			sync_ff <= meta_ff;
		end
	end

	// ==================================================
	// detectors and fault latch
	// shorts only seen after a long enable high
	assign nxt_qual_cnt = !sync_ff.enable ? '0 :
		(qual_cnt_ff == hbc_pkg::QUAL_MAX) ? qual_cnt_ff :
		qual_cnt_ff + 1'b1;
	assign short_trip = sync_ff.short_det && (qual_cnt_ff == hbc_pkg::QUAL_MAX);
	// any detector trips, overcurrent among them
	assign trip = short_trip || sync_ff.ocp_cmp || sync_ff.overheat ||
		// supply drop while enabled is an error
		(sync_ff.supply_low && sync_ff.enable);
	assign nxt_fault = fault_ff || trip;

	// ==================================================
	// current chopping
	assign chop_tick    = (chop_cnt_ff == hbc_pkg::CHOP_LAST);
	assign nxt_chop_cnt = chop_tick ? '0 : chop_cnt_ff + 1'b1;
	// comparator holds low side off to period end
	assign nxt_chop     = sync_ff.chop_cmp || (chop_ff && !chop_tick);

	// ==================================================
	// drive decoding and sequencing
	always_comb
	begin
		tgt = decode_drive(sync_ff.dir_input_a, sync_ff.dir_input_b, sync_ff.enable);
		// enable pwm gates drive through decode
		if (ctrl_ff[hbc_pkg::CTRL_INHIBIT])
			tgt = '0;
		if (chop_ff)
		begin
			tgt.low_switch_a = 1'b0;
			tgt.low_switch_b = 1'b0;
		end
	end

	// partner of a switch to turn on still conducts
	assign hazard = (tgt.high_switch_a && gate_ff.low_switch_a) ||
		(tgt.low_switch_a && gate_ff.high_switch_a) ||
		(tgt.high_switch_b && gate_ff.low_switch_b) ||
		(tgt.low_switch_b && gate_ff.high_switch_b);

	always_comb
	begin
		nxt_state    = state_ff;
		nxt_gate     = '0;
		nxt_dead_cnt = dead_cnt_ff;
		case (state_ff)
			hbc_pkg::ST_RUN:
			begin
				if (trip || fault_ff)
					nxt_state = hbc_pkg::ST_FAULT;
				else if (hazard)
				begin
					nxt_state    = hbc_pkg::ST_DEAD;
					nxt_dead_cnt = hbc_pkg::DEAD_LOAD;
				end
				else
					nxt_gate = tgt;
			end
			hbc_pkg::ST_DEAD:
			begin
				if (trip || fault_ff)
					nxt_state = hbc_pkg::ST_FAULT;
				else if (dead_cnt_ff == '0)
					nxt_state = hbc_pkg::ST_RUN;
				else
					nxt_dead_cnt = dead_cnt_ff - 1'b1;
			end
			hbc_pkg::ST_FAULT:
				nxt_state = hbc_pkg::ST_FAULT;
			default:
				nxt_state = hbc_pkg::ST_FAULT;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff    <= hbc_pkg::ST_RUN;
			gate_ff     <= '0;
			dead_cnt_ff <= '0;
			qual_cnt_ff <= '0;
			chop_cnt_ff <= '0;
			chop_ff     <= 1'b0;
			fault_ff    <= 1'b0;
			fault_n_ff  <= 1'b1;
		end
		else if (ce)
		begin
			state_ff    <= nxt_state;
			gate_ff     <= nxt_gate;
			dead_cnt_ff <= nxt_dead_cnt;
			qual_cnt_ff <= nxt_qual_cnt;
			chop_cnt_ff <= nxt_chop_cnt;
			chop_ff     <= nxt_chop;
			fault_ff    <= nxt_fault;
			fault_n_ff  <= ~nxt_fault;
		end
	end

	// ==================================================
	// interrupt status
	assign irq_ev[hbc_pkg::IRQ_FAULT] = trip && !fault_ff;
	assign irq_ev[hbc_pkg::IRQ_CHOP]  = nxt_chop && !chop_ff;
	assign irq_ev[hbc_pkg::IRQ_DEAD]  = (nxt_state == hbc_pkg::ST_DEAD) &&
		(state_ff == hbc_pkg::ST_RUN);
	assign irq_clr  = wr_clr ? hwdata[hbc_pkg::IRQ_W-1:0] : '0;
	// new event beats a clear in the same cycle
	assign nxt_ists = (ists_ff & ~irq_clr) | irq_ev;

	// ==================================================
	// ahb-lite slave, zero wait states
	assign addr_ok = hsel && htrans[1] && hready && ce;
	assign rd_go   = addr_ok && !hwrite;
	assign wr_go   = addr_ok && hwrite;
	assign wr_ctrl = wr_pend_ff && (wr_addr_ff == hbc_pkg::ADDR_CTRL);
	assign wr_clr  = wr_pend_ff && (wr_addr_ff == hbc_pkg::ADDR_IRQ_CLR);
	assign wr_ien  = wr_pend_ff && (wr_addr_ff == hbc_pkg::ADDR_IRQ_EN);
	assign nxt_ctrl = wr_ctrl ? hwdata : ctrl_ff;
	assign nxt_ien  = wr_ien ? hwdata[hbc_pkg::IRQ_W-1:0] : ien_ff;

	always_comb
	begin
		status       = '0;
		status.gates = gate_ff;
		status.fault = fault_ff;
		status.chop  = chop_ff;
		status.state = state_ff;
		status.dir_a = sync_ff.dir_input_a;
		status.dir_b = sync_ff.dir_input_b;
		status.enable = sync_ff.enable;
	end

	assign rd_data = read_sel(haddr[hbc_pkg::ADDR_W-1:0], ctrl_ff, 32'(status),
		32'(ists_ff), 32'(ien_ff));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff   <= 1'b0;
			wr_addr_ff   <= '0;
			hrdata_ff    <= '0;
			hreadyout_ff <= 1'b1;
			hresp_ff     <= 1'b0;
			ctrl_ff      <= hbc_pkg::CTRL_RST;
			ien_ff       <= hbc_pkg::IRQ_EN_RST[hbc_pkg::IRQ_W-1:0];
			ists_ff      <= '0;
			irq_ff       <= 1'b0;
		end
		else if (ce)
		begin
			wr_pend_ff   <= wr_go;
			wr_addr_ff   <= haddr[hbc_pkg::ADDR_W-1:0];
			hrdata_ff    <= rd_go ? rd_data : '0;
			hreadyout_ff <= 1'b1;
			hresp_ff     <= 1'b0;
			ctrl_ff      <= nxt_ctrl;
			ien_ff       <= nxt_ien;
			ists_ff      <= nxt_ists;
			irq_ff       <= |(nxt_ists & nxt_ien);
		end
	end

	// ==================================================
	// outputs
	assign gates     = gate_ff;
	assign fault_n   = fault_n_ff;
	assign irq       = irq_ff;
	assign hrdata    = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp     = hresp_ff;
endmodule

// [design/hbc_pkg.sv]
// package: constants and types of the h-bridge control block
package hbc_pkg;
	// ==================================================
	// clock and timing
	localparam int CLK_MHZ         = 20;
	localparam int CLK_KHZ         = CLK_MHZ * 1000;
	localparam int DEAD_NS         = 500;
	localparam int DEAD_CYC        = (DEAD_NS * CLK_MHZ + 999) / 1000;
	localparam int SHORT_QUAL_US   = 16;
	localparam int SHORT_QUAL_CYC  = SHORT_QUAL_US * CLK_MHZ;
	localparam int CHOP_KHZ        = 46;
	localparam int CHOP_CYC        = CLK_KHZ / CHOP_KHZ;
	localparam int DEAD_W          = 4;
	localparam int QUAL_W          = 9;
	localparam int CHOP_W          = 9;
	localparam logic [DEAD_W-1:0] DEAD_LOAD  = 4'(DEAD_CYC - 1);
	localparam logic [QUAL_W-1:0] QUAL_MAX   = 9'(SHORT_QUAL_CYC);
	localparam logic [CHOP_W-1:0] CHOP_LAST  = 9'(CHOP_CYC - 1);
	// ==================================================
	// register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 8'h10;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;
	localparam int CTRL_INHIBIT = 0;
	localparam int IRQ_W     = 3;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_CHOP  = 1;
	localparam int IRQ_DEAD  = 2;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	// ==================================================
	// types
	typedef enum logic [2:0]
	{
		ST_RUN   = 3'b001,
		ST_DEAD  = 3'b010,
		ST_FAULT = 3'b100
	} hbc_state_t;

	typedef struct packed
	{
		logic high_switch_a;
		logic low_switch_a;
		logic high_switch_b;
		logic low_switch_b;
	} hbc_gate_t;

	typedef struct packed
	{
		logic dir_input_a;
		logic dir_input_b;
		logic enable;
		logic chop_cmp;
		logic ocp_cmp;
		logic short_det;
		logic overheat;
		logic supply_low;
	} hbc_pins_t;

	typedef struct packed
	{
		logic [19:0] rsvd;
		logic        enable;
		logic        dir_b;
		logic        dir_a;
		logic [2:0]  state;
		logic        chop;
		logic        fault;
		hbc_gate_t   gates;
	} hbc_status_t;
endpackage

// [testbench/hbc_bridge_sva.sv]
// checker: port properties of the bridge control
module hbc_bridge_sva
(
	input logic               hclk,
	input logic               hresetn,
	input hbc_pkg::hbc_pins_t pins,
	input hbc_pkg::hbc_gate_t gates,
	input logic               fault_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==================================================
	// properties, pins seen three edges late
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_fault_off: assert property (!fault_n |-> gates == '0)
		else $error("gate on during fault");
	a_fault_held: assert property (!fault_n |=> !fault_n)
		else $error("fault cleared without reset");
	a_no_shoot: assert property (!(gates.high_switch_a && gates.low_switch_a)
		&& !(gates.high_switch_b && gates.low_switch_b))
		else $error("half bridge shoot through");
	a_ocp_trip: assert property (pins.ocp_cmp |-> ##[1:4] !fault_n)
		else $error("overcurrent not latched");
	a_heat_trip: assert property (pins.overheat |-> ##[1:4] !fault_n)
		else $error("overheat not latched");
	a_supply_trip: assert property (pins.supply_low && pins.enable |-> ##[1:4] !fault_n)
		else $error("supply fall not latched");
	// supply-side brake is the one legal high switch with its input high
	a_half_a: assert property (gates.high_switch_a |->
		!$past(pins.dir_input_a, 3) || $past(pins.dir_input_b && pins.enable, 3))
		else $error("high a on with input a high");
	a_half_b: assert property (gates.high_switch_b |->
		!$past(pins.dir_input_b, 3) || $past(pins.dir_input_a && pins.enable, 3))
		else $error("high b on with input b high");
	a_stop_off: assert property (
		$past(!pins.enable && (pins.dir_input_a || pins.dir_input_b), 3) |-> gates == '0)
		else $error("switch on in stop");
	c_fault: cover property ($fell(fault_n));
	c_fwd: cover property (gates.low_switch_a && gates.high_switch_b);
	c_rev: cover property (gates.high_switch_a && gates.low_switch_b);
endmodule

// [testbench/hbc_ctrl_model.sv]
// model: external controller driving direction and enable
module hbc_ctrl_model
(
	input  logic       hclk,
	input  logic       hresetn,
	input  logic [2:0] cmd,
	output logic       dir_a,
	output logic       dir_b,
	output logic       en
);
	timeunit 1ns;
	timeprecision 1ns;
	// 1us at 20 MHz
	localparam int MIN_CYC = 20;
	int hold;
	// ==================================================
	// enable low across power cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{dir_a, dir_b, en} <= 3'h0;
			hold <= 0;
		end
		else if (hold < MIN_CYC)
			hold <= hold + 1;
		else if (cmd != {dir_a, dir_b, en})
		begin
			{dir_a, dir_b, en} <= cmd;
			hold <= 0;
		end
	end
endmodule

// [testbench/brushed_dc_hbridge_control_test.sv]
// testbench: bus, decode, chop and fault scenarios
module brushed_dc_hbridge_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic               hclk, hresetn, hsel, hwrite, ma, mb, men, hreadyout, hresp, fault_n, irq;
	logic [1:0]         htrans;
	logic [31:0]        haddr, hwdata, hrdata, q;
	logic [2:0]         cmd;
	logic [4:0]         det;
	hbc_pkg::hbc_pins_t pins;
	hbc_pkg::hbc_gate_t gates;
	int                 bad_count, check_count, n, z;
	logic [2:0]         tin [8] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h7, 3'h6, 3'h4, 3'h2};
	logic [3:0]         tg [8] = '{4'h5, 4'h5, 4'h6, 4'h9, 4'hA, 4'h0, 4'h0, 4'h0};
	logic [4:0]         fs [4] = '{5'h08, 5'h04, 5'h02, 5'h01};
	assign pins = {ma, mb, men, det};
	initial
	begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end
	hbc_bridge_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .gates(gates),
		.fault_n(fault_n), .irq(irq));
	hbc_ctrl_model u_ctl (.hclk(hclk), .hresetn(hresetn), .cmd(cmd), .dir_a(ma), .dir_b(mb),
		.en(men));
	// ==================================================
	// tasks
	task close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task lapse();
		bad_count++;
		$display("mismatch wait expired");
		close_out();
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task hop();
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 50);
		if (n >= 50)
			lapse();
	endtask
	// address phase held until hready, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		hop();
		htrans <= hbc_pkg::HTRANS_IDLE;
		hwdata <= d;
		hop();
		q = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk("read", e, q);
		chk("hresp", 32'h0000_0000, 32'(hresp));
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
		repeat (2) @(posedge hclk);
	endtask
	// bound covers a full chop period
	task waitg(input logic [3:0] e);
		n = 0;
		while (gates !== e && n < 500)
		begin
			@(posedge hclk);
			n++;
		end
		chk("gates", 32'(e), 32'(gates));
	endtask
	task pwr();
		hresetn <= 1'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
	endtask
	initial
	begin
		repeat (100000) @(posedge hclk);
		lapse();
	end
	// ==================================================
	// main sequence
	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata} <= '0;
		{cmd, det, bad_count, check_count} = '0;
		pwr();
		waitg(4'h5);
		rd(hbc_pkg::ADDR_STATUS, 32'h0000_0045);
		rd(hbc_pkg::ADDR_IRQ_EN, hbc_pkg::IRQ_EN_RST);
		rd(8'h20, 32'h0000_0000);
		for (int i = 0; i < 8; i++)
		begin
			cmd <= tin[i];
			// model holds a new command back up to its minimum pulse width
			repeat (30) @(posedge hclk);
			waitg(tg[i]);
		end
		cmd <= 3'h5;
		waitg(4'h6);
		wr(hbc_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
		cmd <= 3'h3;
		z = 0;
		for (int k = 0; k < 100 && gates !== 4'h9; k++)
		begin
			@(posedge hclk);
			z += int'(gates === 4'h0);
		end
		chk("dead", 32'h0000_0001, 32'(z >= hbc_pkg::DEAD_CYC));
		chk("gates", 32'h0000_0009, 32'(gates));
		rd(hbc_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
		wr(hbc_pkg::ADDR_IRQ_EN, 32'h0000_0004);
		chk("irq", 32'h0000_0001, 32'(irq));
		wr(hbc_pkg::ADDR_IRQ_EN, 32'h0000_0000);
		chk("irq", 32'h0000_0000, 32'(irq));
		wr(hbc_pkg::ADDR_IRQ_EN, 32'h0000_0004);
		wr(hbc_pkg::ADDR_IRQ_CLR, 32'h0000_0004);
		chk("irq", 32'h0000_0000, 32'(irq));
		det <= 5'h10;
		waitg(4'h8);
		det <= 5'h00;
		waitg(4'h9);
		rd(hbc_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
		wr(hbc_pkg::ADDR_CTRL, 32'h0000_0001);
		waitg(4'h0);
		rd(hbc_pkg::ADDR_CTRL, 32'h0000_0001);
		wr(hbc_pkg::ADDR_CTRL, 32'h0000_0000);
		waitg(4'h9);
		for (int i = 0; i < 4; i++)
		begin
			cmd <= 3'h5;
			waitg(4'h6);
			// enable stays high past 16us for the short case
			det <= fs[i];
			for (int k = 0; k < 500 && fault_n !== 1'h0; k++)
				@(posedge hclk);
			chk("fault_n", 32'h0000_0000, 32'(fault_n));
			chk("gates", 32'h0000_0000, 32'(gates));
			det <= 5'h00;
			cmd <= 3'h3;
			repeat (40) @(posedge hclk);
			chk("gates", 32'h0000_0000, 32'(gates));
			bus(1'h0, hbc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
			chk("irq_stat", 32'h0000_0001, q & 32'h0000_0001);
			cmd <= 3'h0;
			pwr();
			chk("fault_n", 32'h0000_0001, 32'(fault_n));
		end
		close_out();
	end
endmodule
bind hbc_bridge_ctrl hbc_bridge_sva u_sva (.hclk(hclk), .hresetn(hresetn), .pins(pins),
	.gates(gates), .fault_n(fault_n));
